// ---- common/osf_pkg.sv ----
// shared constants and types for the optical sector framer
package osf_pkg;
	// zone selection
	typedef enum logic [1:0] {
		OSF_ZONE_LEADIN = 2'b00,
		OSF_ZONE_DATA = 2'b01,
		OSF_ZONE_CONTROL = 2'b10,
		OSF_ZONE_LEADOUT = 2'b11
	} osf_zone_t;

	// field sequence of one sector
	typedef enum logic [3:0] {
		OSF_F_IDLE = 4'h0,
		OSF_F_MARK = 4'h1,
		OSF_F_LOCK1 = 4'h2,
		OSF_F_ALIGN1 = 4'h3,
		OSF_F_ADDR1 = 4'h4,
		OSF_F_LOCK2 = 4'h5,
		OSF_F_ALIGN2 = 4'h6,
		OSF_F_ADDR2 = 4'h7,
		OSF_F_CLOSE1 = 4'h8,
		OSF_F_GAP = 4'h9,
		OSF_F_LOCK3 = 4'hA,
		OSF_F_SYNC = 4'hB,
		OSF_F_DATA = 4'hC,
		OSF_F_CLOSE2 = 4'hD,
		OSF_F_BUFFER = 4'hE
	} osf_field_t;

	// sector setup from the controller
	typedef struct packed {
		osf_zone_t zone;
		logic [4:0] band;
		logic [15:0] track;
		logic [6:0] sector;
	} osf_setup_t;

	// byte emitted toward the channel
	typedef struct packed {
		osf_field_t field;
		logic [7:0] data;
		logic header;
		logic last;
	} osf_byte_t;

	// field lengths in bytes
	localparam logic [11:0] OSF_LEN_MARK = 12'd8;
	localparam logic [11:0] OSF_LEN_LOCK1 = 12'd26;
	localparam logic [11:0] OSF_LEN_ALIGN = 12'd1;
	localparam logic [11:0] OSF_LEN_ADDR = 12'd5;
	localparam logic [11:0] OSF_LEN_LOCK2 = 12'd16;
	localparam logic [11:0] OSF_LEN_CLOSE = 12'd1;
	localparam logic [11:0] OSF_LEN_GAP = 12'd20;
	localparam logic [11:0] OSF_LEN_LOCK3 = 12'd27;
	localparam logic [11:0] OSF_LEN_SYNC = 12'd4;
	localparam logic [11:0] OSF_LEN_DATA = 12'd2458;
	localparam logic [11:0] OSF_LEN_USER = 12'd2048;
	localparam logic [11:0] OSF_LEN_BUF_CTRL = 12'd121;
	localparam logic [11:0] OSF_LEN_BUF_STD = 12'd58;
	localparam logic [11:0] OSF_LEN_HEADER = 12'd63;
	localparam logic [11:0] OSF_SECTOR_CTRL = 12'd2694;
	localparam logic [11:0] OSF_SECTOR_STD = 12'd2631;

	// geometry
	localparam int OSF_BITS_PER_BYTE = 12;
	localparam logic [6:0] OSF_LAST_SECTOR = 7'd16;
	localparam logic [5:0] OSF_TRACK_BASE = 6'd41;
	localparam logic [4:0] OSF_CTRL_BAND = 5'd17;
	localparam logic [4:0] OSF_LEADIN_BAND = 5'd0;
	localparam int OSF_MARK_BITS = 96;
	localparam int OSF_ALIGN_TOL = 5;

	// sector mark lead-in patterns (6 bits)
	localparam logic [5:0] OSF_LEADIN_ODD = 6'h05;
	localparam logic [5:0] OSF_LEADIN_EVEN = 6'h01;

	// nominal clocks in kHz, reference only
	localparam int OSF_REF_KHZ_BAND0 = 66270;
	localparam int OSF_REF_KHZ_BAND17 = 38790;
	localparam int OSF_REF_KHZ_LEADOUT = 37180;
	localparam int OSF_REF_KHZ_CTRL = 19400;

	// core clock
	localparam int OSF_CORE_NS = 50;

	// address byte 3 copy select bit
	localparam int OSF_COPY_BIT = 7;
	localparam logic [7:0] OSF_FILL_BYTE = 8'hFF;
endpackage

// ---- logic/osf_fifo.sv ----
// parameterised valid/ready fifo for the framer data path
`timescale 1ns/1ps
module osf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	assign in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_q];

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ---- logic/osf_framer.sv ----
// sector format sequencer for the optical channel
// Operation
// (R1) outside control zone header clock is half the recording field clock
// (R2) control zone uses one clock for header and recording field
// (R3) track holds (41 - band) * 12 * 2631 channel bits
// (R4) per-band nominal clocks are reference values only
// (R5) sector starts of adjacent tracks align within 5 channel bits
// (R6) sectors numbered 0 through 16 on each track
// (R7) sector is header, gap, recording field carrying 2048 user bytes
// (R8) sector is 2694 bytes in control zone, 2631 elsewhere
// (R9) header is 63 bytes, gap 20 bytes
// (R10) header order: mark 8, lock 26, align 1, addr 5, lock 16, align 1, addr 5, close 1
// (R11) control recording field: lock 27, sync 4, data 2458, close 1, buffer 121
// (R12) other zones same but buffer 58 bytes
// (R13) spacing tolerance absorbed in the trailing buffer field
// (R14) sector mark lasts 96 channel bits, long marks then lead-in
// (R15) sector mark timing unit is the header channel bit
// (R16) lead-in 000101 in odd bands, 000001 in even bands
// (R17) lead-in zone uses band 0 type, control band 17, lead-out even
// (R18) address: track 2 bytes, copy bit plus sector, 16-bit crc
// (R19) sector mark run lengths are parameters; the code ignores MARK_RUN4 and ends the last long mark at bit 90
`timescale 1ns/1ps
module osf_framer #(
	parameter logic [5:0] MARK_RUN0 = 6'd24,
	parameter logic [5:0] MARK_RUN1 = 6'd8,
	parameter logic [5:0] MARK_RUN2 = 6'd24,
	parameter logic [5:0] MARK_RUN3 = 6'd8,
	parameter logic [5:0] MARK_RUN4 = 6'd26
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire osf_pkg::osf_setup_t setup,
	input wire logic start,
	input wire logic [15:0] addr_crc,
	input wire logic [7:0] user_data,
	input wire logic user_valid,
	output logic user_ready,
	output osf_pkg::osf_byte_t out_byte,
	output logic out_valid,
	input wire logic out_ready,
	output logic busy,
	output logic half_clock,
	output logic [23:0] track_bits,
	output logic [6:0] sector_num,
	output logic [5:0] mark_leadin,
	output logic [95:0] mark_bits
);
	osf_pkg::osf_field_t field_q;
	logic [11:0] cnt_q;
	osf_pkg::osf_setup_t cfg_q;
	logic [6:0] sec_q;
	logic [11:0] user_cnt_q;
	logic [11:0] total_q;
	logic adv;
	logic last_of_field;
	logic [7:0] byte_d;
	logic fifo_ready;
	logic fifo_valid;
	osf_pkg::osf_byte_t fifo_in;
	logic need_user;

	// length of a field in the current zone
	function automatic logic [11:0] field_len(input osf_pkg::osf_field_t f,
		input osf_pkg::osf_zone_t z);
		logic [11:0] l;
		l = 12'd1;
		unique case (f)
			osf_pkg::OSF_F_MARK: l = osf_pkg::OSF_LEN_MARK; // see (R10)
			osf_pkg::OSF_F_LOCK1: l = osf_pkg::OSF_LEN_LOCK1;
			osf_pkg::OSF_F_ALIGN1, osf_pkg::OSF_F_ALIGN2: l = osf_pkg::OSF_LEN_ALIGN;
			osf_pkg::OSF_F_ADDR1, osf_pkg::OSF_F_ADDR2: l = osf_pkg::OSF_LEN_ADDR;
			osf_pkg::OSF_F_LOCK2: l = osf_pkg::OSF_LEN_LOCK2;
			osf_pkg::OSF_F_CLOSE1, osf_pkg::OSF_F_CLOSE2: l = osf_pkg::OSF_LEN_CLOSE;
			osf_pkg::OSF_F_GAP: l = osf_pkg::OSF_LEN_GAP; // see (R9)
			osf_pkg::OSF_F_LOCK3: l = osf_pkg::OSF_LEN_LOCK3; // see (R11)
			osf_pkg::OSF_F_SYNC: l = osf_pkg::OSF_LEN_SYNC;
			osf_pkg::OSF_F_DATA: l = osf_pkg::OSF_LEN_DATA;
			osf_pkg::OSF_F_BUFFER: l = (z == osf_pkg::OSF_ZONE_CONTROL) ?
				osf_pkg::OSF_LEN_BUF_CTRL : osf_pkg::OSF_LEN_BUF_STD; // see (R12)
			osf_pkg::OSF_F_IDLE: l = 12'd1;
		endcase
		return l;
	endfunction

	// band whose sector mark type is used
	function automatic logic mark_odd(input osf_pkg::osf_zone_t z, input logic [4:0] b);
		logic o;
		o = 1'b0;
		unique case (z)
			osf_pkg::OSF_ZONE_LEADIN: o = osf_pkg::OSF_LEADIN_BAND[0]; // see (R17)
			osf_pkg::OSF_ZONE_CONTROL: o = osf_pkg::OSF_CTRL_BAND[0]; // see (R17)
			osf_pkg::OSF_ZONE_LEADOUT: o = 1'b0; // see (R17)
			osf_pkg::OSF_ZONE_DATA: o = b[0];
		endcase
		return o;
	endfunction

	// ========================================
	// clocking and geometry
	// header bits run at half rate outside control zone; the channel
	// uses this to divide its band clock. absolute rate is set by the
	// spindle/pll from track_bits, the nominal table is reference only
	assign half_clock = (cfg_q.zone != osf_pkg::OSF_ZONE_CONTROL); // see (R1) see (R2) see (R4)
	assign track_bits = 24'((osf_pkg::OSF_TRACK_BASE - 6'(cfg_q.band)) * 24'd12
		* 24'(osf_pkg::OSF_SECTOR_STD)); // see (R3)
	assign sector_num = sec_q;

	// ========================================
	// sector mark pattern in header channel bits
	always_comb begin
		logic [95:0] m;
		int pos;
		m = '0;
		pos = 0;
		// long marks alternate with spaces, unit is the header bit
		for (int i = 0; i < 96; i++) begin
			if (i < int'(MARK_RUN0)) m[95-i] = 1'b1; // see (R19) see (R15)
			else if (i < int'(MARK_RUN0 + MARK_RUN1)) m[95-i] = 1'b0;
			else if (i < int'(MARK_RUN0 + MARK_RUN1 + MARK_RUN2)) m[95-i] = 1'b1;
			else if (i < int'(MARK_RUN0 + MARK_RUN1 + MARK_RUN2 + MARK_RUN3)) m[95-i] = 1'b0;
			else if (i < 90) m[95-i] = 1'b1;
		end
		pos = osf_pkg::OSF_MARK_BITS - 6;
		m[5:0] = mark_leadin; // see (R14) see (R16)
		mark_bits = m;
	end
	assign mark_leadin = mark_odd(cfg_q.zone, cfg_q.band) ?
		osf_pkg::OSF_LEADIN_ODD : osf_pkg::OSF_LEADIN_EVEN; // see (R16)

	// ========================================
	// field sequencer
	assign busy = (field_q != osf_pkg::OSF_F_IDLE);
	assign need_user = (field_q == osf_pkg::OSF_F_DATA) && (user_cnt_q < osf_pkg::OSF_LEN_USER);
	assign adv = busy && fifo_ready && (!need_user || user_valid);
	assign user_ready = busy && fifo_ready && need_user;
	assign last_of_field = (cnt_q == field_len(field_q, cfg_q.zone) - 12'd1);

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			field_q <= osf_pkg::OSF_F_IDLE;
			cnt_q <= '0;
		end else if (!busy) begin
			if (start) begin
				field_q <= osf_pkg::OSF_F_MARK; // see (R7)
				cnt_q <= '0;
			end
		end else if (adv) begin
			if (last_of_field) begin
				cnt_q <= '0;
				// buffer ends the sector and soaks up spacing slack
				if (field_q == osf_pkg::OSF_F_BUFFER) begin
					field_q <= osf_pkg::OSF_F_IDLE; // see (R13)
				end else begin
					field_q <= osf_pkg::osf_field_t'(field_q + 4'h1); // see (R10) see (R11)
				end
			end else begin
				cnt_q <= cnt_q + 12'd1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cfg_q <= '0;
		end else if (!busy && start) begin
			cfg_q <= setup;
		end
	end

	// sector number wraps 16 -> 0 when not loaded explicitly
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sec_q <= '0;
		end else if (!busy && start) begin
			sec_q <= (setup.sector > osf_pkg::OSF_LAST_SECTOR) ? 7'd0 : setup.sector; // see (R6)
		end else if (adv && field_q == osf_pkg::OSF_F_BUFFER && last_of_field) begin
			sec_q <= (sec_q == osf_pkg::OSF_LAST_SECTOR) ? 7'd0 : sec_q + 7'd1; // see (R6)
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			user_cnt_q <= '0;
			total_q <= '0;
		end else if (!busy && start) begin
			user_cnt_q <= '0;
			total_q <= '0;
		end else if (adv) begin
			total_q <= total_q + 12'd1; // see (R8)
			if (need_user) begin
				user_cnt_q <= user_cnt_q + 12'd1; // see (R7)
			end
		end
	end

	// ========================================
	// byte content per field
	always_comb begin
		byte_d = 8'h00;
		unique case (field_q)
			osf_pkg::OSF_F_ADDR1, osf_pkg::OSF_F_ADDR2: begin
				unique case (cnt_q[2:0])
					3'd0: byte_d = cfg_q.track[15:8]; // see (R18)
					3'd1: byte_d = cfg_q.track[7:0];
					3'd2: byte_d = {field_q == osf_pkg::OSF_F_ADDR2, sec_q}; // see (R18)
					3'd3: byte_d = addr_crc[15:8];
					default: byte_d = addr_crc[7:0];
				endcase
			end
			osf_pkg::OSF_F_DATA: byte_d = need_user ? user_data : osf_pkg::OSF_FILL_BYTE;
			default: byte_d = 8'h00;
		endcase
	end

	assign fifo_in.field = field_q;
	assign fifo_in.data = byte_d;
	assign fifo_in.header = (field_q <= osf_pkg::OSF_F_CLOSE1); // see (R1) see (R15)
	assign fifo_in.last = (field_q == osf_pkg::OSF_F_BUFFER) && last_of_field; // see (R5)

	osf_fifo #(
		.WIDTH($bits(osf_pkg::osf_byte_t)),
		.DEPTH(32)
	) u_fifo (
		.core_clk(core_clk),
		.nrst(nrst),
		.in_data(fifo_in),
		.in_valid(adv),
		.in_ready(fifo_ready),
		.out_data(out_byte),
		.out_valid(fifo_valid),
		.out_ready(out_ready)
	);
	assign out_valid = fifo_valid;
endmodule

// ---- verif/osf_framer_chk.sv ----
// port-level assertions for the optical sector framer
`timescale 1ns/1ps
module osf_framer_chk (
	input wire logic core_clk,
	input wire logic nrst,
	input wire osf_pkg::osf_setup_t setup,
	input wire logic start,
	input wire osf_pkg::osf_byte_t out_byte,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic busy,
	input wire logic half_clock,
	input wire logic [23:0] track_bits,
	input wire logic [6:0] sector_num,
	input wire logic [5:0] mark_leadin,
	input wire logic [95:0] mark_bits
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	property p_start; !busy && start |=> busy; endproperty
	a_start: assert property (p_start) else $error("busy missing after start");
	property p_half_ctrl; !busy && start && setup.zone == osf_pkg::OSF_ZONE_CONTROL |=> ##1 !half_clock;
	endproperty
	a_half_ctrl: assert property (p_half_ctrl) else $error("half clock in control");
	property p_half_std; !busy && start && setup.zone == osf_pkg::OSF_ZONE_DATA |=> ##1 half_clock;
	endproperty
	a_half_std: assert property (p_half_std) else $error("full clock in header");
	property p_odd; !busy && start && setup.zone == osf_pkg::OSF_ZONE_DATA && setup.band[0]
		|=> ##1 mark_leadin == osf_pkg::OSF_LEADIN_ODD; endproperty
	a_odd: assert property (p_odd) else $error("odd band lead-in wrong");
	property p_even; !busy && start && setup.zone == osf_pkg::OSF_ZONE_LEADIN
		|=> ##1 mark_leadin == osf_pkg::OSF_LEADIN_EVEN; endproperty
	a_even: assert property (p_even) else $error("lead-in zone mark wrong");
	property p_track; $rose(busy) && setup.zone == osf_pkg::OSF_ZONE_DATA
		|=> track_bits == 24'((41 - int'(setup.band)) * 12 * 2631); endproperty
	a_track: assert property (p_track) else $error("track bit count wrong");
	property p_tail; busy |-> mark_bits[5:0] == mark_leadin; endproperty
	a_tail: assert property (p_tail) else $error("mark does not end in lead-in");
	property p_range; sector_num <= 7'h10; endproperty
	a_range: assert property (p_range) else $error("sector number out of range");
	property p_last; out_valid && out_byte.last |-> out_byte.field == osf_pkg::OSF_F_BUFFER;
	endproperty
	a_last: assert property (p_last) else $error("last byte not in buffer");
	property p_hdr; out_valid |-> out_byte.header
		== (out_byte.field inside {[osf_pkg::OSF_F_MARK:osf_pkg::OSF_F_CLOSE1]}); endproperty
	a_hdr: assert property (p_hdr) else $error("header flag wrong");
	property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_byte); endproperty
	a_hold: assert property (p_hold) else $error("byte changed while stalled");
endmodule

// ---- verif/osf_channel_model.sv ----
// far-side channel model that sinks framed bytes and tallies them
`timescale 1ns/1ps
module osf_channel_model (
	input wire logic core_clk,
	input wire logic clear,
	input wire logic stall,
	input wire logic hold,
	input wire osf_pkg::osf_byte_t out_byte,
	input wire logic out_valid,
	output logic out_ready,
	output int total,
	output int hdr,
	output int bad,
	output int last_at,
	output int len [16],
	output logic [7:0] addr [10]
);
	int cyc = 0;
	int dcnt;
	int acnt;
	logic [3:0] prev;
	initial out_ready = 1'b1;
	always @(negedge core_clk) begin
		cyc++;
		out_ready <= !hold && !(stall && (cyc % 3 == 0));
	end
	always @(posedge core_clk) begin
		if (clear) begin
			total = 0; hdr = 0; bad = 0; last_at = 0; dcnt = 0; acnt = 0; prev = 4'h0;
			foreach (len[i]) len[i] = 0;
		end else if (out_valid && out_ready) begin
			total++;
			hdr += out_byte.header;
			len[out_byte.field]++;
			if (out_byte.field != prev && out_byte.field != prev + 1) bad++;
			prev = out_byte.field;
			if (out_byte.last) last_at = total;
			if (out_byte.field inside {osf_pkg::OSF_F_ADDR1, osf_pkg::OSF_F_ADDR2}) begin
				if (acnt < 10) addr[acnt] = out_byte.data;
				acnt++;
			end
			if (out_byte.field == osf_pkg::OSF_F_DATA) begin
				if (out_byte.data !== ((dcnt < 2048) ? 8'(dcnt) : 8'hFF)) bad++;
				dcnt++;
			end
		end
	end
endmodule

// ---- verif/osf_framer_bench.sv ----
// self-checking bench for the optical sector framer
`timescale 1ns/1ps
module osf_framer_bench;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	osf_pkg::osf_setup_t setup = '0;
	logic start = 1'b0;
	logic [15:0] addr_crc = 16'hA55A;
	logic user_valid = 1'b1;
	logic clear = 1'b0, stall = 1'b0, hold = 1'b0, took = 1'b0;
	logic user_ready, out_valid, out_ready, busy, half_clock;
	osf_pkg::osf_byte_t out_byte;
	logic [23:0] track_bits;
	logic [6:0] sector_num;
	logic [5:0] mark_leadin;
	logic [95:0] mark_bits;
	int total, hdr, bad, last_at, len [16];
	logic [7:0] addr [10];
	int n_mismatch = 0, check_count = 0, ucnt = 0;
	int flen [16] = '{0, 8, 26, 1, 5, 16, 1, 5, 1, 20, 27, 4, 2458, 1, 0, 0};
	always #25 core_clk = ~core_clk;
	always @(posedge core_clk) took <= user_valid && user_ready;
	always @(negedge core_clk) if (took) ucnt <= ucnt + 1;
	osf_framer dut (.core_clk(core_clk), .nrst(nrst), .setup(setup), .start(start),
		.addr_crc(addr_crc), .user_data(ucnt[7:0]), .user_valid(user_valid),
		.user_ready(user_ready), .out_byte(out_byte), .out_valid(out_valid),
		.out_ready(out_ready), .busy(busy), .half_clock(half_clock), .track_bits(track_bits),
		.sector_num(sector_num), .mark_leadin(mark_leadin), .mark_bits(mark_bits));
	osf_channel_model chan (.core_clk(core_clk), .clear(clear), .stall(stall), .hold(hold),
		.out_byte(out_byte), .out_valid(out_valid), .out_ready(out_ready), .total(total),
		.hdr(hdr), .bad(bad), .last_at(last_at), .len(len), .addr(addr));
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic begin_sector(input osf_pkg::osf_zone_t z, input logic [4:0] b,
		input logic [6:0] s, input logic [5:0] lead, input logic half);
		@(negedge core_clk);
		setup = '{zone: z, band: b, track: 16'hFFFE, sector: s};
		ucnt = 0; clear = 1'b1; start = 1'b1;
		@(negedge core_clk);
		clear = 1'b0; start = 1'b0;
		repeat (3) @(negedge core_clk);
		check("lead-in", lead, mark_leadin);
		check("half clock", half, half_clock);
	endtask
	task automatic done_sector(input string name, input int size, input int buflen);
		int n = 0;
		while ((busy !== 1'b0 || out_valid !== 1'b0) && n < 30000) begin
			@(negedge core_clk);
			n++;
		end
		check("sector bytes", size, total);
		check("header bytes", 63, hdr);
		check("order or data faults", 0, bad);
		check("last marker", total, last_at);
		for (int f = 1; f < 15; f++) check("field length", f == 14 ? buflen : flen[f], len[f]);
		$display("test %s done", name);
	endtask
	task automatic t_control;
		begin_sector(osf_pkg::OSF_ZONE_CONTROL, 5'h11, 7'h10, 6'h05, 1'b0);
		done_sector("control", 2694, 121);
		check("sector wrap", 7'h00, sector_num);
	endtask
	task automatic t_data_stall;
		int t0;
		stall = 1'b1;
		begin_sector(osf_pkg::OSF_ZONE_DATA, 5'h03, 7'h05, 6'h05, 1'b1);
		check("track bits", (41 - 3) * 12 * 2631, track_bits);
		repeat (200) @(negedge core_clk);
		start = 1'b1;
		@(negedge core_clk);
		start = 1'b0;
		hold = 1'b1;
		repeat (2) @(negedge core_clk);
		t0 = total;
		repeat (60) @(negedge core_clk);
		check("stalled bytes", t0, total);
		check("fifo holds byte", 1'b1, out_valid);
		hold = 1'b0;
		stall = 1'b0;
		done_sector("data stall", 2631, 58);
		for (int i = 0; i < 10; i++) check("address byte", i % 5 == 0 ? 8'hFF : i % 5 == 1
			? 8'hFE : i % 5 == 2 ? {i > 4, 7'h05} : i % 5 == 3 ? 8'hA5 : 8'h5A, addr[i]);
		check("sector next", 7'h06, sector_num);
	endtask
	task automatic t_even_types;
		begin_sector(osf_pkg::OSF_ZONE_LEADIN, 5'h00, 7'h00, 6'h01, 1'b1);
		done_sector("lead-in", 2631, 58);
		begin_sector(osf_pkg::OSF_ZONE_DATA, 5'h04, 7'h02, 6'h01, 1'b1);
		done_sector("even band", 2631, 58);
		begin_sector(osf_pkg::OSF_ZONE_LEADOUT, 5'h00, 7'h03, 6'h01, 1'b1);
		done_sector("lead-out", 2631, 58);
	endtask
	initial begin
		repeat (20) @(negedge core_clk);
		nrst = 1'b1;
		t_control();
		t_data_stall();
		t_even_types();
		close_out();
	end
	initial begin
		#(50 * 40000);
		n_mismatch++;
		$display("watchdog expired");
		close_out();
	end
endmodule
bind osf_framer osf_framer_chk u_chk (.core_clk(core_clk), .nrst(nrst), .setup(setup),
	.start(start), .out_byte(out_byte), .out_valid(out_valid), .out_ready(out_ready),
	.busy(busy), .half_clock(half_clock), .track_bits(track_bits), .sector_num(sector_num),
	.mark_leadin(mark_leadin), .mark_bits(mark_bits));
